// File: cfg_crossing.sv
// Toggle handshake carrying a configuration word to the link domain
`timescale 1ns/10ps
module cfg_crossing #(
  parameter int W = 32
) (
  input wire logic clk_src,
  input wire logic rst_src,
  input wire logic send,
  input wire logic [W-1:0] src_data,
  output logic busy,
  input wire logic clk_dst,
  input wire logic rst_dst,
  output logic [W-1:0] dst_data
);

  logic [W-1:0] hold_ff;
  logic [W-1:0] nxt_hold;
  logic req_ff;
  logic nxt_req;
  logic ack_s1_ff;
  logic ack_s2_ff;
  logic req_s1_ff;
  logic req_s2_ff;
  logic req_s3_ff;
  logic [W-1:0] dst_ff;
  logic [W-1:0] nxt_dst;

  // Source side
  always_comb begin
    nxt_hold = hold_ff;
    nxt_req = req_ff;
    if (send && !busy) begin
      nxt_hold = src_data;
      nxt_req = !req_ff;
    end
  end

  always_ff @(posedge clk_src) begin
    if (rst_src) begin
      hold_ff <= '0;
      req_ff <= 1'b0;
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
    end else begin
      hold_ff <= nxt_hold;
      req_ff <= nxt_req;
      ack_s1_ff <= req_s3_ff;
      ack_s2_ff <= ack_s1_ff;
    end
  end

  assign busy = (req_ff != ack_s2_ff);

  // Destination side
  always_comb begin
    nxt_dst = dst_ff;
    if (req_s2_ff != req_s3_ff) begin
      nxt_dst = hold_ff;
    end
  end

  always_ff @(posedge clk_dst) begin
    if (rst_dst) begin
      req_s1_ff <= 1'b0;
      req_s2_ff <= 1'b0;
      req_s3_ff <= 1'b0;
      dst_ff <= '0;
    end else begin
      req_s1_ff <= req_ff;
      req_s2_ff <= req_s1_ff;
      req_s3_ff <= req_s2_ff;
      dst_ff <= nxt_dst;
    end
  end

  assign dst_data = dst_ff;

endmodule : cfg_crossing

// File: delay_counter.sv
// Loadable down-counter for deselect and inter-transfer delays
`timescale 1ns/10ps
module delay_counter #(
  parameter int W = 13
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic [W-1:0] cnt,
  output logic zero
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (load) begin
      nxt_cnt = load_val;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign cnt = cnt_ff;
  assign zero = (cnt_ff == '0);

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_cnt_load;
    @(posedge clk) disable iff (rst)
    load |=> cnt_ff == $past(load_val);
  endproperty
  a_cnt_load: assert property (p_cnt_load)
    else $error("delay counter did not load");

  property p_cnt_down;
    @(posedge clk) disable iff (rst)
    (!load && cnt_ff != '0) |=> cnt_ff == $past(cnt_ff) - W'(1);
  endproperty
  a_cnt_down: assert property (p_cnt_down)
    else $error("delay counter did not count down");

endmodule : delay_counter

// File: qspi_timing_pkg.sv
// Package of offsets, field layouts, reset values and timing counts
package qspi_timing_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_WPROT = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;

  // Mode register field layout
  localparam int FIELD_W = 8;
  localparam int DESEL_LSB = 24;
  localparam int ITD_LSB = 16;
  localparam int SMM_BIT = 0;
  localparam logic [31:0] MODE_WMASK = 32'hFFFF_0F37;

  // Write protection and status layout
  localparam int WRITE_PROTECT_EN_BIT = 0;
  localparam int ST_CFG_BUSY_BIT = 0;
  localparam int ST_CS_ACTIVE_BIT = 1;
  localparam int ST_CFG_DIRTY_BIT = 2;

  // Reset values
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic WPROT_RESET = 1'b0;

  // Timing counts in link clock periods and delay counter width
  localparam int GAP_UNIT = 32;
  localparam logic [7:0] DESEL_MIN = 8'h01;
  localparam int CNT_W = 13;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACTIVE,
    ST_GAP,
    ST_DESEL
  } link_state_e;

endpackage : qspi_timing_pkg

// File: quad_spi_mode_timing.sv
// Mode register and chip-select timing sequencer of the serial host
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/10ps
module quad_spi_mode_timing (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic clk_link,
  input wire logic start_req,
  input wire logic xfer_done,
  input wire logic xfer_last,
  output logic quad_chip_select_n,
  output logic xfer_go
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [qspi_timing_pkg::CNT_W-1:0] gap_cycles(
    input logic [7:0] itd,
    input logic serial_memory_mode_sel
  );
    gap_cycles = serial_memory_mode_sel ? '0 : qspi_timing_pkg::CNT_W'(itd) *
                 qspi_timing_pkg::CNT_W'(qspi_timing_pkg::GAP_UNIT);
  endfunction : gap_cycles

  function automatic logic [qspi_timing_pkg::CNT_W-1:0] desel_cycles(
    input logic [7:0] d
  );
    desel_cycles = (d == 8'h00) ?
      qspi_timing_pkg::CNT_W'(qspi_timing_pkg::DESEL_MIN) :
      qspi_timing_pkg::CNT_W'(d);
  endfunction : desel_cycles

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  logic [31:0] mode_ff;
  logic [31:0] nxt_mode;
  logic wp_ff;
  logic nxt_wp;
  logic wr_ph_ff;
  logic nxt_wr_ph;
  logic [7:0] waddr_ff;
  logic [7:0] nxt_waddr;
  logic [31:0] hrdata_ff;
  logic [31:0] nxt_hrdata;
  logic hreadyout_ff;
  logic hresp_ff;
  logic dirty_ff;
  logic nxt_dirty;
  logic cfg_busy;
  logic cs_s1_ff;
  logic cs_s2_ff;
  logic accept;
  logic mode_wr_ok;
  logic launch;

  function automatic logic [31:0] read_mux(
    input logic [31:0] a,
    input logic [31:0] mode,
    input logic wp,
    input logic [2:0] st
  );
    read_mux = 32'h0000_0000;
    if (a[31:8] == 24'h00_0000) begin
      unique case (a[7:0])
        qspi_timing_pkg::OFF_MODE: read_mux = mode;
        qspi_timing_pkg::OFF_WPROT: read_mux = {31'h0000_0000, wp};
        qspi_timing_pkg::OFF_STATUS: read_mux = {29'h0000_0000, st};
        default: read_mux = 32'h0000_0000;
      endcase
    end
  endfunction : read_mux

  assign accept = hsel && htrans[1] && hready;
  assign mode_wr_ok = wr_ph_ff && (waddr_ff == qspi_timing_pkg::OFF_MODE) &&
                      !wp_ff;
  assign launch = dirty_ff && !cfg_busy;

  always_comb begin
    nxt_wr_ph = accept && hwrite;
    nxt_waddr = accept ? haddr[7:0] : waddr_ff;
    nxt_hrdata = hrdata_ff;
    if (accept && !hwrite) begin
      nxt_hrdata = read_mux(haddr, mode_ff, wp_ff,
                            {dirty_ff, cs_s2_ff, cfg_busy});
    end
    nxt_mode = mode_ff;
    nxt_wp = wp_ff;
    if (mode_wr_ok) begin
      nxt_mode = hwdata & qspi_timing_pkg::MODE_WMASK;
    end
    if (wr_ph_ff && waddr_ff == qspi_timing_pkg::OFF_WPROT) begin
      nxt_wp = hwdata[qspi_timing_pkg::WRITE_PROTECT_EN_BIT];
    end
    // A new write in the launch cycle keeps the word pending
    nxt_dirty = mode_wr_ok || (dirty_ff && !launch);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_ff <= qspi_timing_pkg::MODE_RESET;
      wp_ff <= qspi_timing_pkg::WPROT_RESET;
      wr_ph_ff <= 1'b0;
      waddr_ff <= 8'h00;
      hrdata_ff <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
      dirty_ff <= 1'b0;
      cs_s1_ff <= 1'b0;
      cs_s2_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      wp_ff <= nxt_wp;
      wr_ph_ff <= nxt_wr_ph;
      waddr_ff <= nxt_waddr;
      hrdata_ff <= nxt_hrdata;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
      dirty_ff <= nxt_dirty;
      cs_s1_ff <= !quad_chip_select_n;
      cs_s2_ff <= cs_s1_ff;
    end
  end

  assign hreadyout = hreadyout_ff;
  assign hrdata = hrdata_ff;
  assign hresp = hresp_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration crossing

  logic rst_l1_ff;
  logic rst_link_ff;
  logic [31:0] cfg_link;

  always_ff @(posedge clk_link) begin
    rst_l1_ff <= rst;
    rst_link_ff <= rst_l1_ff;
  end

  cfg_crossing #(.W(32)) u_cfg_crossing (
    .clk_src(clk_sys),
    .rst_src(rst),
    .send(launch),
    .src_data(mode_ff),
    .busy(cfg_busy),
    .clk_dst(clk_link),
    .rst_dst(rst_link_ff),
    .dst_data(cfg_link)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Link sequencer

  qspi_timing_pkg::link_state_e state_ff;
  qspi_timing_pkg::link_state_e nxt_state;
  logic cs_n_ff;
  logic nxt_cs_n;
  logic go_ff;
  logic nxt_go;
  logic cnt_load;
  logic [qspi_timing_pkg::CNT_W-1:0] cnt_val;
  logic [qspi_timing_pkg::CNT_W-1:0] cnt;
  logic cnt_zero;
  logic [7:0] desel_f;
  logic [7:0] itd_f;
  logic smm_f;
  logic [qspi_timing_pkg::CNT_W-1:0] gap_val;
  logic [qspi_timing_pkg::CNT_W-1:0] desel_val;
  logic last_ff;
  logic nxt_last;

  assign desel_f = cfg_link[qspi_timing_pkg::DESEL_LSB +: 8];
  assign itd_f = cfg_link[qspi_timing_pkg::ITD_LSB +: 8];
  assign smm_f = cfg_link[qspi_timing_pkg::SMM_BIT];
  assign gap_val = gap_cycles(itd_f, smm_f);
  assign desel_val = desel_cycles(desel_f);

  delay_counter #(.W(qspi_timing_pkg::CNT_W)) u_delay_counter (
    .clk(clk_link),
    .rst(rst_link_ff),
    .load(cnt_load),
    .load_val(cnt_val),
    .cnt(cnt),
    .zero(cnt_zero)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_cs_n = cs_n_ff;
    nxt_go = 1'b0;
    cnt_load = 1'b0;
    cnt_val = '0;
    unique case (state_ff)
      qspi_timing_pkg::ST_IDLE: begin
        if (start_req) begin
          nxt_cs_n = 1'b0;
          nxt_go = 1'b1;
          nxt_state = qspi_timing_pkg::ST_ACTIVE;
        end
      end
      qspi_timing_pkg::ST_ACTIVE: begin
        if (xfer_done) begin
          if (gap_val != '0) begin
            cnt_load = 1'b1;
            cnt_val = gap_val;
            nxt_state = qspi_timing_pkg::ST_GAP;
          end else if (xfer_last) begin
            nxt_cs_n = 1'b1;
            cnt_load = 1'b1;
            cnt_val = desel_val;
            nxt_state = qspi_timing_pkg::ST_DESEL;
          end else if (start_req) begin
            nxt_go = 1'b1;
          end else begin
            nxt_state = qspi_timing_pkg::ST_GAP;
          end
        end
      end
      qspi_timing_pkg::ST_GAP: begin
        if (cnt_zero) begin
          if (last_ff) begin
            nxt_cs_n = 1'b1;
            cnt_load = 1'b1;
            cnt_val = desel_val;
            nxt_state = qspi_timing_pkg::ST_DESEL;
          end else if (start_req) begin
            nxt_go = 1'b1;
            nxt_state = qspi_timing_pkg::ST_ACTIVE;
          end
        end
      end
      qspi_timing_pkg::ST_DESEL: begin
        if (cnt_zero) begin
          nxt_state = qspi_timing_pkg::ST_IDLE;
        end
      end
    endcase
  end


  always_comb begin
    nxt_last = last_ff;
    if (state_ff == qspi_timing_pkg::ST_ACTIVE && xfer_done) begin
      nxt_last = xfer_last;
    end
  end

  always_ff @(posedge clk_link) begin
    if (rst_link_ff) begin
      state_ff <= qspi_timing_pkg::ST_IDLE;
      cs_n_ff <= 1'b1;
      go_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cs_n_ff <= nxt_cs_n;
      go_ff <= nxt_go;
      last_ff <= nxt_last;
    end
  end

  assign quad_chip_select_n = cs_n_ff;
  assign xfer_go = go_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [8:0] hi_cnt_ff;
  logic [13:0] gap_cnt_ff;

  always_ff @(posedge clk_link) begin
    if (rst_link_ff) begin
      hi_cnt_ff <= 9'h1FF;
      gap_cnt_ff <= 14'h0000;
    end else begin
      if (!cs_n_ff) begin
        hi_cnt_ff <= 9'h000;
      end else if (hi_cnt_ff != 9'h1FF) begin
        hi_cnt_ff <= hi_cnt_ff + 9'h001;
      end
      if (state_ff == qspi_timing_pkg::ST_ACTIVE && xfer_done) begin
        gap_cnt_ff <= 14'h0000;
      end else if (state_ff == qspi_timing_pkg::ST_GAP) begin
        gap_cnt_ff <= gap_cnt_ff + 14'h0001;
      end
    end
  end

  property p_wp_block;
    @(posedge clk_sys) disable iff (rst)
    (wr_ph_ff && waddr_ff == qspi_timing_pkg::OFF_MODE && wp_ff)
      |=> $stable(mode_ff);
  endproperty
  a_wp_block: assert property (p_wp_block)
    else $error("mode register changed while protected");

  property p_wr_accept;
    @(posedge clk_sys) disable iff (rst)
    mode_wr_ok |=> mode_ff == ($past(hwdata) & qspi_timing_pkg::MODE_WMASK);
  endproperty
  a_wr_accept: assert property (p_wr_accept)
    else $error("unprotected mode write not taken");

  property p_bus_ok;
    @(posedge clk_sys) disable iff (rst)
    hreadyout && !hresp;
  endproperty
  a_bus_ok: assert property (p_bus_ok)
    else $error("bus answer not ready and okay");

  property p_desel_zero;
    @(posedge clk_link) disable iff (rst_link_ff)
    ($fell(cs_n_ff) && desel_f == 8'h00) |-> hi_cnt_ff >= 9'h001;
  endproperty
  a_desel_zero: assert property (p_desel_zero)
    else $error("chip select reasserted without one idle period");

  property p_desel_n;
    @(posedge clk_link) disable iff (rst_link_ff)
    $fell(cs_n_ff) |-> hi_cnt_ff >= {1'b0, desel_f};
  endproperty
  a_desel_n: assert property (p_desel_n)
    else $error("deselect time shorter than programmed");

  property p_gap;
    @(posedge clk_link) disable iff (rst_link_ff)
    (go_ff && $past(state_ff) == qspi_timing_pkg::ST_GAP && gap_val != '0)
      |-> gap_cnt_ff >= {1'b0, gap_val};
  endproperty
  a_gap: assert property (p_gap)
    else $error("inter-transfer gap too short");

  property p_nogap;
    @(posedge clk_link) disable iff (rst_link_ff)
    (state_ff == qspi_timing_pkg::ST_ACTIVE && xfer_done && !xfer_last &&
     start_req && gap_val == '0) |=> go_ff && !cs_n_ff;
  endproperty
  a_nogap: assert property (p_nogap)
    else $error("gap inserted with zero delay");

  property p_smm;
    @(posedge clk_link) disable iff (rst_link_ff)
    (state_ff == qspi_timing_pkg::ST_ACTIVE && xfer_done && smm_f)
      |=> state_ff != qspi_timing_pkg::ST_GAP || gap_cnt_ff == 14'h0000;
  endproperty
  a_smm: assert property (p_smm)
    else $error("delay inserted in serial memory mode");

  c_desel: cover property (@(posedge clk_link) disable iff (rst_link_ff)
    state_ff == qspi_timing_pkg::ST_DESEL ##1
    state_ff == qspi_timing_pkg::ST_IDLE);
  c_gap: cover property (@(posedge clk_link) disable iff (rst_link_ff)
    state_ff == qspi_timing_pkg::ST_GAP ##1 go_ff);
  c_wp: cover property (@(posedge clk_sys) disable iff (rst)
    wr_ph_ff && waddr_ff == qspi_timing_pkg::OFF_MODE && wp_ff);

endmodule : quad_spi_mode_timing

// File: quad_spi_mode_timing_tb.sv
// Testbench for the mode register and chip-select timing block
`timescale 1ns/10ps
module quad_spi_mode_timing_tb;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic start_req;
  logic xfer_done;
  logic xfer_last;
  logic quad_chip_select_n;
  logic xfer_go;
  logic run = 1'b0;
  int gap_last;
  int desel_last;
  int frames;
  int miscompares = 0;
  int checked = 0;
  logic [31:0] rd;
  logic [7:0] dsl [5] = '{8'h00, 8'h05, 8'h00, 8'h03, 8'h02};
  logic [7:0] itd [5] = '{8'h00, 8'h00, 8'h01, 8'h02, 8'h00};
  logic serial_memory_mode_sel [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

  always #4 clk_sys = ~clk_sys;
  always #7.5 clk_link = ~clk_link;

  quad_spi_mode_timing u_quad_spi_mode_timing (
    .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .clk_link(clk_link), .start_req(start_req),
    .xfer_done(xfer_done), .xfer_last(xfer_last),
    .quad_chip_select_n(quad_chip_select_n), .xfer_go(xfer_go)
  );

  quad_spi_slave_model u_quad_spi_slave_model (
    .clk_link(clk_link), .run(run), .burst_len(4'h2),
    .quad_chip_select_n(quad_chip_select_n), .xfer_go(xfer_go),
    .start_req(start_req), .xfer_done(xfer_done), .xfer_last(xfer_last),
    .gap_last(gap_last), .desel_last(desel_last), .frames(frames)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, comparison, bus and frame-run tasks
  task automatic end_of_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bus_wait();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      miscompares++;
      end_of_test();
    end
  endtask : bus_wait

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    bus_wait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    bus_wait();
    rd = hrdata;
    check({31'h0000_0000, hresp}, 32'h0000_0000);
  endtask : bus

  task automatic settle();
    int n;
    for (n = 0; n < 100; n++) begin
      bus(1'b0, qspi_timing_pkg::OFF_STATUS, 32'h0000_0000);
      if ((rd & 32'h0000_0005) === 32'h0000_0000) break;
    end
    if (n == 100) begin
      miscompares++;
      end_of_test();
    end
  endtask : settle

  task automatic run_frames(input int want);
    int n;
    int f0;
    f0 = frames;
    @(posedge clk_link) run <= 1'b1;
    for (n = 0; n < 40000 && frames < f0 + want; n++) @(posedge clk_sys);
    @(posedge clk_link) run <= 1'b0;
    for (n = 0; n < 5000; n++) begin
      @(posedge clk_sys);
      if (quad_chip_select_n === 1'b1 && start_req === 1'b0) break;
    end
    if (frames < f0 + want || n == 5000) begin
      miscompares++;
      end_of_test();
    end
  endtask : run_frames

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int i;
    int dmin;
    int g;
    logic ok_d;
    logic ok_g;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    bus(1'b0, qspi_timing_pkg::OFF_MODE, 32'h0000_0000);
    check(rd, qspi_timing_pkg::MODE_RESET);
    bus(1'b0, qspi_timing_pkg::OFF_WPROT, 32'h0000_0000);
    check(rd, {31'h0000_0000, qspi_timing_pkg::WPROT_RESET});
    bus(1'b1, qspi_timing_pkg::OFF_MODE, 32'hFFFF_FFFF);
    bus(1'b0, qspi_timing_pkg::OFF_MODE, 32'h0000_0000);
    check(rd, qspi_timing_pkg::MODE_WMASK);
    bus(1'b1, qspi_timing_pkg::OFF_WPROT, 32'h0000_0001);
    bus(1'b1, qspi_timing_pkg::OFF_MODE, 32'h0102_0000);
    bus(1'b0, qspi_timing_pkg::OFF_MODE, 32'h0000_0000);
    check(rd, qspi_timing_pkg::MODE_WMASK);
    bus(1'b1, qspi_timing_pkg::OFF_WPROT, 32'h0000_0000);
    bus(1'b1, qspi_timing_pkg::OFF_MODE, 32'h0102_0000);
    bus(1'b0, qspi_timing_pkg::OFF_MODE, 32'h0000_0000);
    check(rd, 32'h0102_0000);
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    bus(1'b0, 8'h40, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    for (i = 0; i < 5; i++) begin
      bus(1'b1, qspi_timing_pkg::OFF_MODE,
          {dsl[i], itd[i], 15'h0000, serial_memory_mode_sel[i]});
      settle();
      run_frames(3);
      dmin = (dsl[i] == 8'h00) ? 1 : int'(dsl[i]);
      g = (itd[i] == 8'h00 || serial_memory_mode_sel[i]) ? 0 : 32 * int'(itd[i]);
      ok_d = desel_last >= dmin && desel_last <= dmin + 4;
      ok_g = (g == 0) ? (gap_last == 1) :
             (gap_last >= g + 2 && gap_last <= g + 4);
      check(32'(ok_d), 32'h0000_0001);
      check(32'(ok_g), 32'h0000_0001);
    end
    end_of_test();
  end
endmodule : quad_spi_mode_timing_tb

// File: quad_spi_slave_model.sv
// Serial slave model driving the link-side transfer handshake
`timescale 1ns/10ps
module quad_spi_slave_model #(
  parameter int XLEN = 4
) (
  input wire logic clk_link,
  input wire logic run,
  input wire logic [3:0] burst_len,
  input wire logic quad_chip_select_n,
  input wire logic xfer_go,
  output logic start_req,
  output logic xfer_done,
  output logic xfer_last,
  output int gap_last,
  output int desel_last,
  output int frames
);
  logic busy;
  int cnt;
  int idx;
  int since_done;
  int cs_hi;

  initial begin
    start_req = 1'b0;
    xfer_done = 1'b0;
    xfer_last = 1'b0;
    busy = 1'b0;
    cnt = 0;
    idx = 0;
    since_done = 0;
    cs_hi = 0;
    gap_last = 0;
    desel_last = 0;
    frames = 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencing; done only after go, one per transfer
  always @(posedge clk_link) begin
    xfer_done <= 1'b0;
    xfer_last <= ~xfer_last;
    since_done <= since_done + 1;
    cs_hi <= quad_chip_select_n ? cs_hi + 1 : 0;
    if (!quad_chip_select_n && cs_hi != 0) begin
      desel_last <= cs_hi;
      frames <= frames + 1;
    end
    if (busy) begin
      if (cnt == XLEN - 1) begin
        busy <= 1'b0;
        xfer_done <= 1'b1;
        xfer_last <= (idx == int'(burst_len) - 1);
        idx <= (idx == int'(burst_len) - 1) ? 0 : idx + 1;
        start_req <= run || (idx != int'(burst_len) - 1);
        since_done <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end else if (xfer_go) begin
      busy <= 1'b1;
      cnt <= 0;
      start_req <= 1'b0;
      if (idx != 0) begin
        gap_last <= since_done;
      end
    end else if (idx == 0) begin
      start_req <= run;
    end
  end
endmodule : quad_spi_slave_model
